//--- verilog/tx_desc_dma_pkg.sv
// package: descriptor layout, register map and carrier types for the transmit descriptor dma
package tx_desc_dma_pkg;
   // ***********************************************
   // descriptor word 0 field positions
   // ***********************************************
   localparam int OWN_BIT = 31;
   localparam int IRQ_ON_COMPLETION_BIT = 30;
   localparam int LAST_SEGMENT_BIT = 29;
   localparam int FIRST_SEGMENT_BIT = 28;
   localparam int CRC_SUPPRESS_BIT = 27;
   localparam int PAD_SUPPRESS_BIT = 26;
   localparam int TIMESTAMP_REQUEST_BIT = 25;
   localparam int CKSUM_HI_BIT = 23;
   localparam int CKSUM_LO_BIT = 22;
   localparam int END_OF_RING_BIT = 21;
   localparam int CHAINED_BIT = 20;
   localparam int CTRL_LO_BIT = 18;
   localparam int TIMESTAMP_CAPTURED_BIT = 17;
   // ***********************************************
   // descriptor word 1 and word offsets
   // ***********************************************
   localparam int BUF2_SIZE_HI = 28;
   localparam int BUF2_SIZE_LO = 16;
   localparam int BUF_SIZE_W = 13;
   localparam logic [31:0] WORD0_OFS = 32'h0000_0000;
   localparam logic [31:0] WORD6_OFS = 32'h0000_0018;
   localparam logic [31:0] WORD7_OFS = 32'h0000_001C;
   localparam logic [31:0] DESC_SIZE_SMALL = 32'h0000_0010;
   localparam logic [31:0] DESC_SIZE_LARGE = 32'h0000_0020;
   localparam logic [1:0] LAST_FETCH_WORD = 2'h3;
   // ***********************************************
   // register map (byte addresses)
   // ***********************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] POLL_OFS = 8'h04;
   localparam logic [7:0] BASE_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] CUR_DESC_OFS = 8'h10;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_DESC_LARGE_BIT = 1;
   localparam int STATUS_TX_IRQ_BIT = 0;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   // ***********************************************
   // carriers and states
   // ***********************************************
   typedef struct packed {
      logic crc_suppress;
      logic pad_suppress;
      logic timestamp_request;
      logic [1:0] checksum_insert_mode;
   } frame_ctrl_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [BUF_SIZE_W-1:0] len;
      logic sof;
      logic eof;
   } buf_req_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_FETCH = 4'h1,
      ST_CHECK = 4'h3,
      ST_BUF1 = 4'h2,
      ST_BUF2 = 4'h6,
      ST_WAIT = 4'h7,
      ST_WB0 = 4'h5,
      ST_WB6 = 4'h4,
      ST_WB7 = 4'hC,
      ST_NEXT = 4'hD,
      ST_SUSP = 4'hF
   } dma_state_t;
endpackage

//--- verilog/tx_desc_dma.sv
// module: transmit descriptor walker with ahb-lite control registers
//
// Function
// RULE1 - step descriptors by 16 or 32 bytes
// RULE2 - software sets large size for timestamping
// RULE3 - buffer sizes up to 8 KB
// RULE4 - always fetch exactly four descriptor words
// RULE5 - write back controls, clear owner, status
// RULE6 - owner bit 31: set dma, clear host
// RULE7 - host sets first owner bit last
// RULE8 - completion irq on last segment frame done
// RULE9 - last segment needs non-zero buffer size
// RULE10 - frame controls only from first segment
// RULE11 - crc suppress drops appended check sequence
// RULE12 - short frames padded with crc unless suppressed
// RULE13 - timestamp request captures frame timestamp
// RULE14 - write timestamp words six, seven, flag
// RULE15 - timestamp flag only in last segment
// RULE16 - two-bit checksum insertion mode select
// RULE17 - end of ring returns to base
// RULE18 - chain uses word three, ring wins
// RULE19 - word one holds both buffer sizes
// RULE20 - word two, three are addresses
// RULE21 - no limit on descriptors per frame
// RULE22 - zero first size skips buffer one
// RULE23 - host-owned descriptor suspends processing
// RULE24 - sequential next address adds descriptor size
`timescale 1ns/1ps
module tx_desc_dma
   import tx_desc_dma_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // descriptor memory master
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // buffer hand-off to the mac transmitter
   output logic buf_valid,
   output buf_req_t buf_req,
   output frame_ctrl_t frame_ctrl,
   input wire logic buf_ready,
   // frame completion from the mac transmitter
   input wire logic tx_done,
   input wire logic [7:0] tx_status,
   input wire logic ts_valid,
   input wire logic [63:0] ts_value
);
   // ***********************************************
   // declarations
   // ***********************************************
   logic [1:0] ctrl_reg;
   logic [31:0] base_reg;
   logic poll_reg;
   logic irq_reg;
   logic [7:0] a_addr_reg;
   logic a_wr_reg;
   logic a_act_reg;
   logic [31:0] rd_data;
   dma_state_t state_reg;
   logic [31:0] cur_reg;
   logic [1:0] idx_reg;
   logic [31:0] w0_reg, w1_reg, w2_reg, w3_reg;
   logic sof_pend_reg;
   logic done_set_reg;
   logic poll_clr_reg;
   logic [7:0] stat_reg;
   logic ts_cap_reg;
   logic [63:0] ts_reg;
   logic hresp_reg;
   // ***********************************************
   // decoded descriptor fields
   // ***********************************************
   wire enable = ctrl_reg[CTRL_ENABLE_BIT];
   wire desc_large = ctrl_reg[CTRL_DESC_LARGE_BIT];
   wire own = w0_reg[OWN_BIT]; // RULE6
   wire last_seg = w0_reg[LAST_SEGMENT_BIT];
   wire first_seg = w0_reg[FIRST_SEGMENT_BIT];
   wire chained = w0_reg[CHAINED_BIT];
   wire end_ring = w0_reg[END_OF_RING_BIT];
   wire [BUF_SIZE_W-1:0] size1 = w1_reg[BUF_SIZE_W-1:0]; // RULE19 RULE3
   wire [BUF_SIZE_W-1:0] size2 = w1_reg[BUF2_SIZE_HI:BUF2_SIZE_LO]; // RULE19
   wire use_buf2 = !chained && (size2 != '0); // RULE18
   wire [31:0] step = desc_large ? DESC_SIZE_LARGE : DESC_SIZE_SMALL; // RULE1
   wire [31:0] next_addr = end_ring ? base_reg : (chained ? w3_reg : cur_reg + step); // RULE17 RULE18 RULE24
   wire ts_flag = ts_cap_reg && last_seg; // RULE15
   wire [31:0] wb0 = {1'b0, w0_reg[30:CTRL_LO_BIT], ts_flag, 9'h000, stat_reg}; // RULE5 RULE14
   wire wr_ctrl = a_act_reg && a_wr_reg && (a_addr_reg == CTRL_OFS);
   wire wr_poll = a_act_reg && a_wr_reg && (a_addr_reg == POLL_OFS);
   wire wr_base = a_act_reg && a_wr_reg && (a_addr_reg == BASE_OFS);
   wire wr_stat = a_act_reg && a_wr_reg && (a_addr_reg == STATUS_OFS);
   wire irq_clr = wr_stat && hwdata[STATUS_TX_IRQ_BIT];
   wire mem_done = mem_req && mem_ack;
   wire buf_done = buf_valid && buf_ready;
   // ***********************************************
   // register read mux
   // ***********************************************
   always_comb begin
      if (a_addr_reg == CTRL_OFS) begin
         rd_data = {30'h0000_0000, ctrl_reg};
      end else if (a_addr_reg == BASE_OFS) begin
         rd_data = base_reg;
      end else if (a_addr_reg == STATUS_OFS) begin
         rd_data = {26'h000_0000, state_reg, state_reg == ST_SUSP, irq_reg};
      end else if (a_addr_reg == CUR_DESC_OFS) begin
         rd_data = cur_reg;
      end else begin
         rd_data = 32'h0000_0000;
      end
   end
   // ***********************************************
   // ahb-lite slave: one wait state per transfer
   // ***********************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_act_reg <= 1'b0;
         a_wr_reg <= 1'b0;
         a_addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp_reg <= 1'b0;
      end else if (a_act_reg) begin
         a_act_reg <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= a_wr_reg ? 32'h0000_0000 : rd_data;
      end else if (hsel && hready && htrans[1]) begin
         a_act_reg <= 1'b1;
         a_wr_reg <= hwrite;
         a_addr_reg <= {haddr[7:2], 2'h0};
         hreadyout <= 1'b0;
      end
   end
   assign hresp = hresp_reg;
   // ***********************************************
   // software registers
   // ***********************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         base_reg <= BASE_RESET;
         poll_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= hwdata[1:0];
         end
         if (wr_base) begin
            base_reg <= hwdata;
         end
         poll_reg <= wr_poll | (poll_reg & ~poll_clr_reg);
         irq_reg <= done_set_reg | (irq_reg & ~irq_clr); // RULE8
      end
   end
   // ***********************************************
   // descriptor walker
   // ***********************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         cur_reg <= 32'h0000_0000;
         idx_reg <= 2'h0;
         w0_reg <= 32'h0000_0000;
         w1_reg <= 32'h0000_0000;
         w2_reg <= 32'h0000_0000;
         w3_reg <= 32'h0000_0000;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         buf_valid <= 1'b0;
         buf_req <= '0;
         frame_ctrl <= '0;
         sof_pend_reg <= 1'b0;
         done_set_reg <= 1'b0;
         poll_clr_reg <= 1'b0;
         stat_reg <= 8'h00;
         ts_cap_reg <= 1'b0;
         ts_reg <= 64'h0000_0000_0000_0000;
      end else begin
         done_set_reg <= 1'b0;
         poll_clr_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (enable) begin
                  cur_reg <= base_reg;
                  idx_reg <= 2'h0;
                  poll_clr_reg <= 1'b1;
                  state_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= cur_reg + {28'h000_0000, idx_reg, 2'h0}; // RULE4
               end else if (mem_done) begin
                  mem_req <= 1'b0;
                  case (idx_reg)
                     2'h0: w0_reg <= mem_rdata;
                     2'h1: w1_reg <= mem_rdata;
                     2'h2: w2_reg <= mem_rdata; // RULE20
                     default: w3_reg <= mem_rdata; // RULE20
                  endcase
                  idx_reg <= idx_reg + 2'h1;
                  if (idx_reg == LAST_FETCH_WORD) begin
                     state_reg <= ST_CHECK; // RULE4
                  end
               end
            end
            ST_CHECK: begin
               if (!own) begin
                  state_reg <= ST_SUSP; // RULE23
               end else begin
                  if (first_seg) begin
                     sof_pend_reg <= 1'b1;
                     ts_cap_reg <= 1'b0;
                     frame_ctrl.crc_suppress <= w0_reg[CRC_SUPPRESS_BIT]; // RULE10 RULE11
                     frame_ctrl.pad_suppress <= w0_reg[PAD_SUPPRESS_BIT]; // RULE10 RULE12
                     frame_ctrl.timestamp_request <= w0_reg[TIMESTAMP_REQUEST_BIT]; // RULE10 RULE13
                     frame_ctrl.checksum_insert_mode <= w0_reg[CKSUM_HI_BIT:CKSUM_LO_BIT]; // RULE10 RULE16
                  end
                  if (size1 != '0) begin
                     state_reg <= ST_BUF1;
                  end else if (use_buf2) begin
                     state_reg <= ST_BUF2; // RULE22
                  end else begin
                     state_reg <= last_seg ? ST_WAIT : ST_WB0; // RULE22 RULE9
                  end
               end
            end
            ST_BUF1: begin
               if (!buf_valid) begin
                  buf_valid <= 1'b1;
                  buf_req <= '{addr: w2_reg, len: size1, sof: sof_pend_reg, eof: last_seg && !use_buf2};
                  sof_pend_reg <= 1'b0;
               end else if (buf_done) begin
                  buf_valid <= 1'b0;
                  state_reg <= use_buf2 ? ST_BUF2 : (last_seg ? ST_WAIT : ST_WB0);
               end
            end
            ST_BUF2: begin
               if (!buf_valid) begin
                  buf_valid <= 1'b1;
                  buf_req <= '{addr: w3_reg, len: size2, sof: sof_pend_reg, eof: last_seg};
                  sof_pend_reg <= 1'b0;
               end else if (buf_done) begin
                  buf_valid <= 1'b0;
                  state_reg <= last_seg ? ST_WAIT : ST_WB0; // RULE21
               end
            end
            ST_WAIT: begin
               if (tx_done) begin
                  stat_reg <= tx_status; // RULE5
                  ts_cap_reg <= ts_valid && frame_ctrl.timestamp_request; // RULE13
                  ts_reg <= ts_value;
                  state_reg <= ST_WB0;
               end
            end
            ST_WB0: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= cur_reg + WORD0_OFS;
                  mem_wdata <= wb0; // RULE5 RULE6
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  state_reg <= (ts_flag && desc_large) ? ST_WB6 : ST_NEXT; // RULE14 RULE2
               end
            end
            ST_WB6: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= cur_reg + WORD6_OFS;
                  mem_wdata <= ts_reg[31:0]; // RULE14
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  state_reg <= ST_WB7;
               end
            end
            ST_WB7: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= cur_reg + WORD7_OFS;
                  mem_wdata <= ts_reg[63:32]; // RULE14
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  state_reg <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               done_set_reg <= last_seg && w0_reg[IRQ_ON_COMPLETION_BIT]; // RULE8
               stat_reg <= 8'h00;
               if (last_seg) begin
                  ts_cap_reg <= 1'b0;
               end
               cur_reg <= next_addr; // RULE17 RULE18 RULE24
               idx_reg <= 2'h0;
               state_reg <= enable ? ST_FETCH : ST_IDLE;
            end
            ST_SUSP: begin
               if (!enable) begin
                  state_reg <= ST_IDLE;
               end else if (poll_reg) begin
                  poll_clr_reg <= 1'b1;
                  idx_reg <= 2'h0;
                  state_reg <= ST_FETCH; // RULE23
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // tx_desc_dma

//--- tb/desc_mem.sv
// memory model: descriptor store with a selectable answer delay
`timescale 1ns/1ps
module desc_mem (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // descriptor access
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [1:0] slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] m [0:63];
   logic [1:0] wait_reg;
   wire hit = mem_req && !mem_ack && (wait_reg == slow);
   // read data is only meaningful in the ack cycle, so it toggles otherwise
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 1'h0;
         wait_reg <= 2'h0;
         mem_rdata <= 32'h0;
      end else begin
         mem_ack <= hit;
         mem_rdata <= (hit && !mem_we) ? m[mem_addr[7:2]] : ~mem_rdata;
         wait_reg <= (mem_req && !mem_ack && !hit) ? wait_reg + 2'h1 : 2'h0;
         if (hit && mem_we) m[mem_addr[7:2]] <= mem_wdata;
      end
   end
endmodule // desc_mem

//--- tb/tx_desc_dma_assertions.sv
// checker: port-level properties of the transmit descriptor dma
`timescale 1ns/1ps
module tx_desc_dma_assertions
   import tx_desc_dma_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // descriptor memory
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // buffer hand-off
   input wire logic buf_valid,
   input wire buf_req_t buf_req,
   input wire logic buf_ready
);
   logic [31:0] word0_reg;
   wire word0_wr = mem_req && mem_we && (mem_addr[3:0] == 4'h0);
   wire word0_rd = mem_req && mem_ack && !mem_we && (mem_addr[3:0] == 4'h0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) word0_reg <= 32'h0;
      else if (word0_rd) word0_reg <= mem_rdata;
   end
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ******************
   // properties
   // ******************
   property p_ahb_wait;
      hsel && hready && htrans[1] && hreadyout |=> !hreadyout && !hresp ##1 hreadyout;
   endproperty
   a_ahb_wait: assert property (p_ahb_wait) else $error("ahb data phase timing wrong");
   property p_mem_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory request changed before ack");
   property p_fetch_step;
      mem_req && mem_ack && !mem_we && mem_addr[3:2] != 2'h3
         |=> !mem_req ##1 (mem_req && !mem_we && mem_addr == $past(mem_addr, 2) + 32'h4);
   endproperty
   a_fetch_step: assert property (p_fetch_step) else $error("descriptor fetch not four words");
   property p_wb_own;
      word0_wr |-> !mem_wdata[31] && mem_wdata[30:8] == {word0_reg[30:18], mem_wdata[17], 9'h0};
   endproperty
   a_wb_own: assert property (p_wb_own) else $error("word0 writeback wrong");
   property p_ts_flag_last;
      word0_wr && mem_wdata[17] |-> mem_wdata[29];
   endproperty
   a_ts_flag_last: assert property (p_ts_flag_last) else $error("ts flag outside last segment");
   property p_ts_pair;
      mem_req && mem_ack && mem_we && mem_addr[4:0] == 5'h18
         |=> !mem_req ##1 (mem_req && mem_we && mem_addr == $past(mem_addr, 2) + 32'h4);
   endproperty
   a_ts_pair: assert property (p_ts_pair) else $error("ts high word not after low word");
   property p_buf_hold;
      buf_valid && !buf_ready |=> buf_valid && $stable(buf_req);
   endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("buffer offer changed while stalled");
   property p_buf_nonzero;
      buf_valid |-> buf_req.len != 13'h0;
   endproperty
   a_buf_nonzero: assert property (p_buf_nonzero) else $error("empty buffer offered");
   c_eof: cover property (buf_valid && buf_ready && buf_req.eof);
   c_ts: cover property (mem_req && mem_we && mem_addr[4:0] == 5'h1C);
   c_stall: cover property (buf_valid && !buf_ready);
endmodule // tx_desc_dma_assertions
bind tx_desc_dma tx_desc_dma_assertions tx_desc_dma_assertions_inst (.hclk, .hresetn, .hsel, .htrans,
   .hready, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
   .buf_valid, .buf_req, .buf_ready);

//--- tb/tb.sv
// testbench: descriptor walks of the transmit dma over ahb-lite
`timescale 1ns/1ps
module tb;
   import tx_desc_dma_pkg::*;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, buf_ready = 1'h0;
   logic tx_done = 1'h0, ts_valid = 1'h0, hready, hresp, mem_req, mem_we, mem_ack, buf_valid;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_addr, mem_wdata, mem_rdata, q;
   logic [1:0] htrans = 2'h0, slow = 2'h0;
   buf_req_t buf_req;
   frame_ctrl_t frame_ctrl;
   logic [51:0] bq[$];
   int fails = 0, checks_done = 0, nrd = 0, nwr = 0, dcnt = 0;
   localparam logic [31:0] TSL = 32'h1234_5678, TSH = 32'h9ABC_DEF0, MASK = 32'h7FFC_0000;
   always #20 hclk = ~hclk;
   tx_desc_dma tx_desc_dma_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hreadyout(hready), .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
      .mem_rdata, .buf_valid, .buf_req, .frame_ctrl, .buf_ready, .tx_done, .tx_status(8'h5A), .ts_valid,
      .ts_value({TSH, TSL}));
   desc_mem desc_mem_inst (.hclk, .hresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow, .mem_ack,
      .mem_rdata);
   // ******************
   // mac side and monitors
   // ******************
   always @(posedge hclk) begin
      buf_ready <= ~buf_ready;
      if (mem_req && mem_ack && mem_we) nwr++;
      if (mem_req && mem_ack && !mem_we) nrd++;
      if (buf_valid && buf_ready) bq.push_back({buf_req, frame_ctrl});
      if (buf_valid && buf_ready && buf_req.eof) dcnt = 3;
      tx_done <= (dcnt == 1);
      ts_valid <= (dcnt == 1);
      if (dcnt > 0) dcnt--;
   end
   // ******************
   // tasks
   // ******************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      q = hrdata;
   endtask
   task automatic rst();
      hresetn <= 1'h0;
      repeat (10) @(posedge hclk);
      for (int i = 0; i < 64; i++) desc_mem_inst.m[i] = 32'h0;
      bq.delete();
      nrd = 0;
      nwr = 0;
      hresetn <= 1'h1;
   endtask
   task automatic wait_susp();
      q = 32'h0;
      for (int i = 0; i < 400 && q[1] !== 1'h1; i++) xfer(1'h0, STATUS_OFS, 32'h0);
      chk(q[1], 1'h1);
   endtask
   task automatic dsc(input logic [7:0] a, input logic [31:0] w0, w1, w2, w3);
      desc_mem_inst.m[a[7:2] + 6'h1] = w1;
      desc_mem_inst.m[a[7:2] + 6'h2] = w2;
      desc_mem_inst.m[a[7:2] + 6'h3] = w3;
      desc_mem_inst.m[a[7:2]] = w0;
   endtask
   function automatic logic [31:0] d0(int k);
      return {4'hF, k[0], k[1], 2'h0, k[1:0], 22'h0};
   endfunction
   function automatic logic [12:0] sz(int k);
      return (k == 0) ? 13'h0 : (k == 3) ? 13'h1FFF : 13'(k * 16);
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end
   // ******************
   // scenarios
   // ******************
   initial begin
      logic [4:0] fc;
      rst();
      chk({hready, hresp, mem_req, buf_valid}, 4'h8);
      xfer(1'h0, CTRL_OFS, 32'h0);
      chk(q, {30'h0, CTRL_RESET});
      xfer(1'h0, BASE_OFS, 32'h0);
      chk(q, BASE_RESET);
      xfer(1'h1, 8'h20, 32'hFFFF_FFFF);
      xfer(1'h0, 8'h20, 32'h0);
      chk(q, 32'h0);
      // sequential 16-byte list, every checksum mode, zero and maximum sizes
      for (int k = 0; k < 4; k++) dsc(8'(k * 16), d0(k), {3'h0, 13'h8, 3'h0, sz(k)}, 32'h1000_0000 + k,
         32'h2000_0000 + k);
      xfer(1'h1, CTRL_OFS, 32'h1);
      wait_susp();
      for (int k = 0; k < 4; k++) begin
         fc = {k[0], k[1], 1'h0, k[1:0]};
         if (k != 0) chk(bq.pop_front(), {32'h1000_0000 + k, sz(k), 2'h2, fc});
         chk(bq.pop_front(), {32'h2000_0000 + k, 13'h8, k == 0, 1'h1, fc});
         chk(desc_mem_inst.m[k * 4], (d0(k) & MASK) | 32'h5A);
      end
      chk(nrd, 20);
      chk(nwr, 4);
      xfer(1'h0, CUR_DESC_OFS, 32'h0);
      chk(q, 32'h40);
      xfer(1'h0, STATUS_OFS, 32'h0);
      chk(q[1:0], 2'h3);
      xfer(1'h1, STATUS_OFS, 32'h1);
      xfer(1'h0, STATUS_OFS, 32'h0);
      chk(q[0], 1'h0);
      dsc(8'h40, 32'hB000_0000, 32'h4, 32'h4000_0000, 32'h0);
      xfer(1'h1, POLL_OFS, 32'h1);
      wait_susp();
      chk(bq.pop_front(), {32'h4000_0000, 13'h4, 2'h3, 5'h0});
      chk(desc_mem_inst.m[16], 32'h3000_005A);
      xfer(1'h0, CUR_DESC_OFS, 32'h0);
      chk(q, 32'h50);
      // 32-byte chained frame of two descriptors, ring bit over chain, timestamp
      rst();
      chk({hready, hresp, mem_req, buf_valid}, 4'h8);
      slow <= 2'h2;
      dsc(8'hC0, 32'hE430_0000, 32'h10, 32'h3000_1000, 32'h40);
      dsc(8'h80, 32'h9A90_0000, 32'h0055_0020, 32'h3000_0000, 32'hC0);
      xfer(1'h1, BASE_OFS, 32'h80);
      xfer(1'h1, CTRL_OFS, 32'h3);
      wait_susp();
      chk(bq.pop_front(), {32'h3000_0000, 13'h20, 2'h2, 5'h16});
      chk(bq.pop_front(), {32'h3000_1000, 13'h10, 2'h1, 5'h16});
      chk(desc_mem_inst.m[32], 32'h1A90_0000);
      chk(desc_mem_inst.m[48], 32'h6432_005A);
      chk({desc_mem_inst.m[55], desc_mem_inst.m[54]}, {TSH, TSL});
      chk(desc_mem_inst.m[38], 32'h0);
      chk(nrd, 12);
      chk(nwr, 4);
      xfer(1'h0, CUR_DESC_OFS, 32'h0);
      chk(q, 32'h80);
      print_verdict();
   end
endmodule // tb
